// >>> hw/cspp_defs.svh
// offsets, field positions and reset values of the colour-space pixel processor
`ifndef CSPP_DEFS_SVH
`define CSPP_DEFS_SVH

// ************************************************************
// register map (byte addresses on the plain register port)
// ************************************************************
`define CSPP_ADDR_W 8
`define CSPP_OFS_CTRL 8'h00
`define CSPP_OFS_GAIN_RED 8'h04
`define CSPP_OFS_GAIN_GREEN 8'h08
`define CSPP_OFS_GAIN_BLUE 8'h0C
`define CSPP_OFS_CORE_THR 8'h10
`define CSPP_OFS_LUT_ADDR 8'h14
`define CSPP_OFS_LUT_DATA 8'h18
`define CSPP_OFS_STATUS 8'h1C
`define CSPP_OFS_PIX_COUNT 8'h20

// ************************************************************
// control register fields
// ************************************************************
`define CSPP_CTRL_GAIN_EN 0
`define CSPP_CTRL_LUT_EN 1
`define CSPP_CTRL_HSL_EN 2
`define CSPP_CTRL_CORE_EN 3
`define CSPP_CTRL_FMT_LSB 4
`define CSPP_CTRL_FMT_MSB 5
`define CSPP_CTRL_W 6

// lut address register: table select above an 8-bit index
`define CSPP_LUT_IDX_MSB 7
`define CSPP_LUT_SEL_LSB 8
`define CSPP_LUT_SEL_MSB 9

// ************************************************************
// reset values and arithmetic constants
// ************************************************************
`define CSPP_CTRL_RST 6'h00
`define CSPP_GAIN_RST 8'h40
`define CSPP_GAIN_FRAC 6
`define CSPP_CORE_RST 8'h10
`define CSPP_FIFO_DEPTH 8
`define CSPP_HUE_SIXTH 16'sh002B
`define CSPP_HUE_GREEN 8'h55
`define CSPP_HUE_BLUE 8'hAB

`endif

// >>> hw/cspp_pkg.sv
// types and arithmetic helpers shared by the colour-space pixel processor
`include "cspp_defs.svh"

package cspp_pkg;

  // ************************************************************
  // output word format
  // ************************************************************
  typedef enum logic [1:0] {
    CSPP_FMT_PACKED,
    CSPP_FMT_HUE,
    CSPP_FMT_SAT,
    CSPP_FMT_LUM
  } cspp_fmt_type;

  typedef logic [7:0] cspp_chan_type;

  // ************************************************************
  // helper functions
  // ************************************************************

  // gain multiply with 6 fraction bits, clipped to 8 bits
  function automatic cspp_chan_type gain_sat(input cspp_chan_type v, input cspp_chan_type g);
    logic [15:0] prod;
    logic [9:0] shifted;
    prod = {8'h00, v} * {8'h00, g};
    shifted = prod[`CSPP_GAIN_FRAC+9:`CSPP_GAIN_FRAC];
    gain_sat = (shifted > 10'h0FF) ? 8'hFF : shifted[7:0];
  endfunction

  // rgb to {hue, saturation, luminance}, all on a 0..255 scale
  function automatic logic [23:0] rgb_to_hsl(input cspp_chan_type r, input cspp_chan_type g,
                                            input cspp_chan_type b);
    cspp_chan_type mx;
    cspp_chan_type mn;
    cspp_chan_type d;
    cspp_chan_type base;
    cspp_chan_type h;
    cspp_chan_type s;
    logic [8:0] sum;
    logic [8:0] den;
    logic [15:0] sn;
    logic [15:0] sq;
    logic signed [8:0] num;
    logic signed [15:0] prod;
    logic signed [15:0] dv;
    logic signed [15:0] q;
    mx = (r > g) ? ((r > b) ? r : b) : ((g > b) ? g : b);
    mn = (r < g) ? ((r < b) ? r : b) : ((g < b) ? g : b);
    d = mx - mn;
    sum = {1'b0, mx} + {1'b0, mn};
    den = (sum <= 9'h0FF) ? sum : (9'h1FE - sum);
    sn = {8'h00, d} * 16'h00FF;
    sq = (d == 8'h00) ? 16'h0000 : sn / {7'h00, den};
    s = sq[7:0];
    // hue sector picked by the largest channel, red wins ties
    if (mx == r) begin
      base = 8'h00;
      num = $signed({1'b0, g}) - $signed({1'b0, b});
    end else if (mx == g) begin
      base = `CSPP_HUE_GREEN;
      num = $signed({1'b0, b}) - $signed({1'b0, r});
    end else begin
      base = `CSPP_HUE_BLUE;
      num = $signed({1'b0, r}) - $signed({1'b0, g});
    end
    prod = {{7{num[8]}}, num} * `CSPP_HUE_SIXTH;
    dv = $signed({8'h00, d});
    q = (d == 8'h00) ? 16'sh0000 : prod / dv;
    h = (d == 8'h00) ? 8'h00 : base + q[7:0]; // negative offsets wrap round the colour circle
    rgb_to_hsl = {h, s, sum[8:1]};
  endfunction

endpackage

// >>> hw/cspp_store.sv
// storage of the pixel processor: lookup memory and output fifo

// ************************************************************
// 256 x 8 lookup memory, one write port, registered read
// ************************************************************
module cspp_lut_mem
  import cspp_pkg::*;
#(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**AW];

  // table load from the register port
  always_ff @(posedge clk) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // read data from a register, one cycle after the address
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= '0;
    end else if (ce && re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

// ************************************************************
// synchronous fifo with valid/ready on both sides
// ************************************************************
module cspp_fifo
  import cspp_pkg::*;
#(
  parameter int W = 32,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] count_reg;
  logic push;
  logic pop;

  assign in_ready = (count_reg != (PW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];
  assign push = ce & in_valid & in_ready;
  assign pop = ce & out_valid & out_ready;

  // storage writes
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + PW'(1);
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + PW'(1);
      end
    end
  end

  // fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_reg <= '0;
    end else if (push && !pop) begin
      count_reg <= count_reg + (PW+1)'(1);
    end else if (pop && !push) begin
      count_reg <= count_reg - (PW+1)'(1);
    end
  end
endmodule

// >>> hw/cspp_core.sv
// colour-space pixel processor: gain, lookup, hsl conversion, coring, output packing
// Function
// - Red, green and blue samples are taken from the decoder and every processed pixel is passed to the memory side.
// - Gain, lookup, conversion and coring each switch off alone and pass data unchanged; single-plane formats leave converted values even with conversion off.
// - Red, green and blue are each scaled by a separately programmed gain for white balance.
// - Each channel is remapped through its own programmable lookup table, independent of the others.
// - When conversion is selected each pixel is turned into hue, saturation and luminance.
// - When coring is on, hue is forced to zero for pixels whose saturation is below a programmed threshold.
// - A pixel can leave as one 32-bit word holding either its rgb or its hsl components.
// - Instead, a single hue, saturation or luminance plane can leave as one 8-bit value per pixel.
//
// The address-and-strobe port and the register addresses were decided locally.
`include "cspp_defs.svh"

module cspp_core
  import cspp_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic [`CSPP_ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  input wire logic PIX_VALID,
  input wire logic [7:0] PIX_RED,
  input wire logic [7:0] PIX_GREEN,
  input wire logic [7:0] PIX_BLUE,
  output logic PIX_READY,
  output logic OUT_VALID,
  output logic [31:0] OUT_DATA,
  input wire logic OUT_READY
);

  // ************************************************************
  // declarations
  // ************************************************************
  logic [`CSPP_CTRL_W-1:0] ctrl_reg;
  cspp_chan_type gain_reg [3];
  cspp_chan_type core_thr_reg;
  logic [`CSPP_LUT_SEL_MSB:0] lut_addr_reg;
  logic [15:0] pix_count_reg;
  logic [3:0] occ_reg;
  logic [3:0] occ_next;
  logic pix_ready_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  logic in_valid_reg;
  cspp_chan_type in_pix_reg [3];
  logic gain_valid_reg;
  cspp_chan_type gain_pix_reg [3];
  logic lut_valid_reg;
  cspp_chan_type byp_pix_reg [3];
  cspp_chan_type lut_q [3];
  cspp_chan_type lut_out [3];
  logic col_valid_reg;
  cspp_chan_type rgb_reg [3];
  cspp_chan_type hue_reg;
  cspp_chan_type sat_reg;
  cspp_chan_type lum_reg;
  logic word_valid_reg;
  logic [31:0] word_reg;
  logic [31:0] word_next;
  logic [23:0] hsl_c;
  cspp_fmt_type fmt;

  logic out_valid_reg;
  logic [31:0] out_data_reg;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_out_data;
  logic fifo_pop;
  logic pipe_adv;
  logic take;
  logic lut_we;
  cspp_chan_type pix_in [3];

  // ************************************************************
  // handshake terms
  // ************************************************************

  // the fifo ready stalls the whole pipeline; credit counting keeps it from ever happening
  assign pipe_adv = CLK_EN & (~word_valid_reg | fifo_in_ready);
  assign take = pipe_adv & PIX_VALID & pix_ready_reg;
  assign fifo_pop = CLK_EN & fifo_out_valid & (~out_valid_reg | OUT_READY);
  assign lut_we = CLK_EN & REG_WR & (REG_ADDR == `CSPP_OFS_LUT_DATA);
  assign fmt = cspp_fmt_type'(ctrl_reg[`CSPP_CTRL_FMT_MSB:`CSPP_CTRL_FMT_LSB]);
  assign pix_in[0] = PIX_RED;
  assign pix_in[1] = PIX_GREEN;
  assign pix_in[2] = PIX_BLUE;

  // ************************************************************
  // register port: writes
  // ************************************************************

  // configuration registers
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_reg <= `CSPP_CTRL_RST;
      gain_reg[0] <= `CSPP_GAIN_RST;
      gain_reg[1] <= `CSPP_GAIN_RST;
      gain_reg[2] <= `CSPP_GAIN_RST;
      core_thr_reg <= `CSPP_CORE_RST;
    end else if (CLK_EN && REG_WR) begin
      case (REG_ADDR)
        `CSPP_OFS_CTRL: ctrl_reg <= REG_WDATA[`CSPP_CTRL_W-1:0];
        `CSPP_OFS_GAIN_RED: gain_reg[0] <= REG_WDATA[7:0];
        `CSPP_OFS_GAIN_GREEN: gain_reg[1] <= REG_WDATA[7:0];
        `CSPP_OFS_GAIN_BLUE: gain_reg[2] <= REG_WDATA[7:0];
        `CSPP_OFS_CORE_THR: core_thr_reg <= REG_WDATA[7:0];
        default: ;
      endcase
    end
  end

  // table pointer steps on each data write so a table loads with back-to-back writes
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      lut_addr_reg <= '0;
    end else if (CLK_EN && REG_WR && REG_ADDR == `CSPP_OFS_LUT_ADDR) begin
      lut_addr_reg <= REG_WDATA[`CSPP_LUT_SEL_MSB:0];
    end else if (lut_we) begin
      lut_addr_reg[`CSPP_LUT_IDX_MSB:0] <= lut_addr_reg[`CSPP_LUT_IDX_MSB:0] + 8'h01;
    end
  end

  // ************************************************************
  // register port: reads
  // ************************************************************

  // read mux; unmapped addresses and the write-only table port read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (REG_RD) begin
      case (REG_ADDR)
        `CSPP_OFS_CTRL: rdata_next = {26'h0, ctrl_reg};
        `CSPP_OFS_GAIN_RED: rdata_next = {24'h0, gain_reg[0]};
        `CSPP_OFS_GAIN_GREEN: rdata_next = {24'h0, gain_reg[1]};
        `CSPP_OFS_GAIN_BLUE: rdata_next = {24'h0, gain_reg[2]};
        `CSPP_OFS_CORE_THR: rdata_next = {24'h0, core_thr_reg};
        `CSPP_OFS_LUT_ADDR: rdata_next = {22'h0, lut_addr_reg};
        `CSPP_OFS_STATUS: rdata_next = {24'h0, occ_reg, 1'b0, out_valid_reg, pix_ready_reg,
                                        (in_valid_reg | gain_valid_reg | lut_valid_reg |
                                         col_valid_reg | word_valid_reg)};
        `CSPP_OFS_PIX_COUNT: rdata_next = {16'h0, pix_count_reg};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rdata_reg <= 32'h0000_0000;
    end else if (CLK_EN) begin
      rdata_reg <= rdata_next;
    end
  end

  // ************************************************************
  // input acceptance by credit
  // ************************************************************

  // occupancy counts pixels from acceptance until they leave the fifo
  always_comb begin
    occ_next = occ_reg;
    if (take && !fifo_pop) begin
      occ_next = occ_reg + 4'h1;
    end else if (fifo_pop && !take) begin
      occ_next = occ_reg - 4'h1;
    end
  end

  // ready is registered, so it looks at the next occupancy to avoid overfilling
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      occ_reg <= 4'h0;
      pix_ready_reg <= 1'b0;
    end else if (CLK_EN) begin
      occ_reg <= occ_next;
      pix_ready_reg <= (occ_next < 4'(`CSPP_FIFO_DEPTH));
    end
  end

  // ************************************************************
  // stages 0 to 2: capture, gain, lookup (per channel)
  // ************************************************************

  // valid bits of the front stages
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      in_valid_reg <= 1'b0;
      gain_valid_reg <= 1'b0;
      lut_valid_reg <= 1'b0;
    end else if (pipe_adv) begin
      in_valid_reg <= take;
      gain_valid_reg <= in_valid_reg;
      lut_valid_reg <= gain_valid_reg;
    end
  end

  for (genvar c = 0; c < 3; c++) begin : g_chan
    // sample capture, gain and bypass copy beside the table read
    always_ff @(posedge MCLK or posedge SYS_RST) begin
      if (SYS_RST) begin
        in_pix_reg[c] <= 8'h00;
        gain_pix_reg[c] <= 8'h00;
        byp_pix_reg[c] <= 8'h00;
      end else if (pipe_adv) begin
        if (take) begin
          in_pix_reg[c] <= pix_in[c];
        end
        gain_pix_reg[c] <= ctrl_reg[`CSPP_CTRL_GAIN_EN] ? gain_sat(in_pix_reg[c], gain_reg[c])
                                                      : in_pix_reg[c];
        byp_pix_reg[c] <= gain_pix_reg[c];
      end
    end

    // each channel owns its table; loads only reach the selected one
    cspp_lut_mem #(
      .AW(8),
      .DW(8)
    ) u_lut (
      .clk(MCLK),
      .rst(SYS_RST),
      .ce(CLK_EN),
      .we(lut_we && lut_addr_reg[`CSPP_LUT_SEL_MSB:`CSPP_LUT_SEL_LSB] == 2'(c)),
      .waddr(lut_addr_reg[`CSPP_LUT_IDX_MSB:0]),
      .wdata(REG_WDATA[7:0]),
      .re(pipe_adv),
      .raddr(gain_pix_reg[c]),
      .rdata(lut_q[c])
    );

    assign lut_out[c] = ctrl_reg[`CSPP_CTRL_LUT_EN] ? lut_q[c] : byp_pix_reg[c];
  end

  // ************************************************************
  // stage 3: colour conversion and coring
  // ************************************************************
  assign hsl_c = rgb_to_hsl(lut_out[0], lut_out[1], lut_out[2]);

  // conversion runs on every pixel; the enable only picks which result leaves
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      col_valid_reg <= 1'b0;
      rgb_reg[0] <= 8'h00;
      rgb_reg[1] <= 8'h00;
      rgb_reg[2] <= 8'h00;
      hue_reg <= 8'h00;
      sat_reg <= 8'h00;
      lum_reg <= 8'h00;
    end else if (pipe_adv) begin
      col_valid_reg <= lut_valid_reg;
      rgb_reg[0] <= lut_out[0];
      rgb_reg[1] <= lut_out[1];
      rgb_reg[2] <= lut_out[2];
      // grey pixels carry unstable hue, so it is zeroed below the threshold
      if (ctrl_reg[`CSPP_CTRL_CORE_EN] && hsl_c[15:8] < core_thr_reg) begin
        hue_reg <= 8'h00;
      end else begin
        hue_reg <= hsl_c[23:16];
      end
      sat_reg <= hsl_c[15:8];
      lum_reg <= hsl_c[7:0];
    end
  end

  // ************************************************************
  // stage 4: output word packing
  // ************************************************************

  // packed word or a single plane in the low byte
  always_comb begin
    word_next = 32'h0000_0000;
    case (fmt)
      CSPP_FMT_PACKED: begin
        if (ctrl_reg[`CSPP_CTRL_HSL_EN]) begin
          word_next = {8'h00, hue_reg, sat_reg, lum_reg};
        end else begin
          word_next = {8'h00, rgb_reg[0], rgb_reg[1], rgb_reg[2]};
        end
      end
      CSPP_FMT_HUE: word_next = {24'h0, hue_reg};
      CSPP_FMT_SAT: word_next = {24'h0, sat_reg};
      CSPP_FMT_LUM: word_next = {24'h0, lum_reg};
      default: word_next = 32'h0000_0000;
    endcase
  end

  // word held until the fifo takes it
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      word_valid_reg <= 1'b0;
      word_reg <= 32'h0000_0000;
    end else if (pipe_adv) begin
      word_valid_reg <= col_valid_reg;
      word_reg <= word_next;
    end
  end

  // ************************************************************
  // output fifo and output register
  // ************************************************************
  cspp_fifo #(
    .W(32),
    .DEPTH(`CSPP_FIFO_DEPTH)
  ) u_fifo (
    .clk(MCLK),
    .rst(SYS_RST),
    .ce(CLK_EN),
    .in_valid(word_valid_reg),
    .in_data(word_reg),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(~out_valid_reg | OUT_READY)
  );

  // registered output stage, refilled in the same cycle it is taken
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      out_valid_reg <= 1'b0;
      out_data_reg <= 32'h0000_0000;
    end else if (CLK_EN) begin
      if (fifo_pop) begin
        out_valid_reg <= 1'b1;
        out_data_reg <= fifo_out_data;
      end else if (OUT_READY) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  // delivered pixel count; any write to it clears it, a delivery in that cycle still counts
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pix_count_reg <= 16'h0000;
    end else if (CLK_EN) begin
      if (REG_WR && REG_ADDR == `CSPP_OFS_PIX_COUNT) begin
        pix_count_reg <= {15'h0000, (out_valid_reg & OUT_READY)};
      end else if (out_valid_reg && OUT_READY) begin
        pix_count_reg <= pix_count_reg + 16'h0001;
      end
    end
  end

  assign REG_RDATA = rdata_reg;
  assign PIX_READY = pix_ready_reg;
  assign OUT_VALID = out_valid_reg;
  assign OUT_DATA = out_data_reg;

endmodule

// >>> testbench/cspp_core_asserts.sv
// port checker of the colour-space pixel processor
`include "cspp_defs.svh"

module cspp_core_asserts
  import cspp_pkg::*;
(
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic [`CSPP_ADDR_W-1:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [31:0] REG_RDATA,
  input wire logic PIX_VALID,
  input wire logic [7:0] PIX_RED,
  input wire logic [7:0] PIX_GREEN,
  input wire logic [7:0] PIX_BLUE,
  input wire logic PIX_READY,
  input wire logic OUT_VALID,
  input wire logic [31:0] OUT_DATA,
  input wire logic OUT_READY
);
  // ************************************************************
  // control shadow and assertions
  // ************************************************************
  logic [5:0] ctrl_reg;

  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  // shadow of the control word, so format-dependent checks know the mode
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ctrl_reg <= `CSPP_CTRL_RST;
    end else if (CLK_EN && REG_WR && REG_ADDR == `CSPP_OFS_CTRL) begin
      ctrl_reg <= REG_WDATA[5:0];
    end
  end

  chk_rdata_quiet: assert property (CLK_EN && !REG_RD |=> REG_RDATA == 32'h0)
    else $error("read data not zero outside a read");
  chk_ctrl_readback: assert property (CLK_EN && REG_RD && REG_ADDR == `CSPP_OFS_CTRL
    |=> REG_RDATA == {26'h0, ctrl_reg}) else $error("control readback differs");
  chk_gain_width: assert property (CLK_EN && REG_RD && REG_ADDR == `CSPP_OFS_GAIN_BLUE
    |=> REG_RDATA[31:8] == 24'h0) else $error("gain wider than 8 bits");
  chk_lut_wonly: assert property (CLK_EN && REG_RD && REG_ADDR == `CSPP_OFS_LUT_DATA
    |=> REG_RDATA == 32'h0) else $error("table data port reads nonzero");
  chk_out_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DATA))
    else $error("output word changed before taken");
  chk_top_zero: assert property (OUT_VALID |-> OUT_DATA[31:24] == 8'h0)
    else $error("top byte of output word not zero");
  chk_plane_byte: assert property (OUT_VALID && ctrl_reg[5:4] != 2'h0 |-> OUT_DATA[31:8] == 24'h0)
    else $error("plane output wider than 8 bits");
  chk_take_latency: assert property (CLK_EN && PIX_VALID && PIX_READY && OUT_READY && !OUT_VALID
    |-> ##[1:7] OUT_VALID) else $error("pixel not delivered in time");
endmodule

bind cspp_core cspp_core_asserts i_chk (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD),
  .REG_RDATA(REG_RDATA), .PIX_VALID(PIX_VALID), .PIX_RED(PIX_RED), .PIX_GREEN(PIX_GREEN),
  .PIX_BLUE(PIX_BLUE), .PIX_READY(PIX_READY), .OUT_VALID(OUT_VALID), .OUT_DATA(OUT_DATA),
  .OUT_READY(OUT_READY));

// >>> testbench/cspp_sink_model.sv
// downstream memory side: takes output words, can stall or run slow
module cspp_sink_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic vld,
  input wire logic [31:0] data,
  input wire logic stall,
  input wire logic slow,
  output logic rdy
);
  timeunit 1ns;
  timeprecision 1ns;
  logic ph;
  logic [31:0] got[$];

  // ready withheld while stalled, and every other cycle when slow
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdy <= 1'b0;
      ph <= 1'b0;
    end else begin
      ph <= ~ph;
      rdy <= !stall && !(slow && ph);
      if (vld && rdy) begin
        got.push_back(data);
      end
    end
  end
endmodule

// >>> testbench/tb.sv
// self-checking bench of the colour-space pixel processor
`include "cspp_defs.svh"

module tb
  import cspp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'b0;
  logic rst, ce, rw, rr, pv, stall, slow, prdy, ovld, ordy;
  logic [7:0] ra, pr, pg, pb;
  logic [31:0] wd, rdata, odata;
  logic [31:0] expq[$];
  int n_fail, compares, k, i;

  // ************************************************************
  // clock, design and far side
  // ************************************************************
  always #50 mclk = ~mclk;

  cspp_core i_dut (.MCLK(mclk), .SYS_RST(rst), .CLK_EN(ce), .REG_ADDR(ra), .REG_WDATA(wd),
    .REG_WR(rw), .REG_RD(rr), .REG_RDATA(rdata), .PIX_VALID(pv), .PIX_RED(pr), .PIX_GREEN(pg),
    .PIX_BLUE(pb), .PIX_READY(prdy), .OUT_VALID(ovld), .OUT_DATA(odata), .OUT_READY(ordy));
  cspp_sink_model i_sink (.clk(mclk), .rst(rst), .vld(ovld), .data(odata), .stall(stall),
    .slow(slow), .rdy(ordy));

  // ************************************************************
  // access tasks
  // ************************************************************
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // strobe left high so back-to-back writes never toggle it in one step
  task wr(input logic [7:0] a, input logic [31:0] d);
    rw <= 1'b1;
    rr <= 1'b0;
    ra <= a;
    wd <= d;
    @(posedge mclk);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    rr <= 1'b1;
    rw <= 1'b0;
    ra <= a;
    @(posedge mclk);
    rr <= 1'b0;
    @(posedge mclk);
    cmp(rdata, e);
  endtask

  // pixel held until taken; valid stays up for a following pixel
  task px(input logic [23:0] p, input logic [31:0] e);
    int n;
    rw <= 1'b0;
    pv <= 1'b1;
    {pr, pg, pb} <= p;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (prdy !== 1'b1 && n < 50);
    expq.push_back(e);
  endtask

  task drain;
    int n;
    pv <= 1'b0;
    n = 0;
    while (i_sink.got.size() < expq.size() && n < 300) begin
      @(posedge mclk);
      n++;
    end
    cmp(32'(i_sink.got.size()), 32'(expq.size()));
    while (expq.size() > 0 && i_sink.got.size() > 0) cmp(i_sink.got.pop_front(), expq.pop_front());
    expq.delete();
    i_sink.got.delete();
  endtask

  task results;
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    {rst, ce, rw, rr, pv, stall, slow} = 7'h60;
    {ra, pr, pg, pb, wd} = '0;
    n_fail = 0;
    compares = 0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    // reset values, an unmapped place, and a write lost with the enable low
    rd(`CSPP_OFS_CTRL, 32'h0);
    rd(`CSPP_OFS_GAIN_BLUE, 32'h40);
    rd(8'h40, 32'h0);
    ce <= 1'b0;
    wr(`CSPP_OFS_CORE_THR, 32'h77);
    ce <= 1'b1;
    rd(`CSPP_OFS_CORE_THR, 32'h10);
    px(24'h123456, 32'h00123456);
    drain;
    // idle status shows only ready; one delivery counted
    rd(`CSPP_OFS_STATUS, 32'h2);
    rd(`CSPP_OFS_PIX_COUNT, 32'h1);
    // red doubled and clipped at 255, green halved
    wr(`CSPP_OFS_GAIN_RED, 32'h80);
    wr(`CSPP_OFS_GAIN_GREEN, 32'h20);
    wr(`CSPP_OFS_CTRL, 32'h01);
    px(24'h904010, 32'h00FF2010);
    drain;
    // one entry in each table, gain off again
    for (k = 0; k < 3; k++) begin
      wr(`CSPP_OFS_LUT_ADDR, 32'(k * 256 + 17 * (k + 1)));
      wr(`CSPP_OFS_LUT_DATA, 32'(8'hA1 + 17 * k));
    end
    wr(`CSPP_OFS_CTRL, 32'h02);
    px(24'h112233, 32'h00A1B2C3);
    drain;
    rd(`CSPP_OFS_LUT_DATA, 32'h0);
    // primaries and a faint green without coring
    wr(`CSPP_OFS_CTRL, 32'h04);
    px(24'hFF0000, 32'h0000FF7F);
    px(24'h00FF00, 32'h0055FF7F);
    px(24'h0000FF, 32'h00ABFF7F);
    px(24'h808480, 32'h00550482);
    drain;
    // coring: faint green loses its hue, strong green keeps it
    wr(`CSPP_OFS_CTRL, 32'h0C);
    px(24'h808480, 32'h00000482);
    px(24'h00FF00, 32'h0055FF7F);
    drain;
    // each single plane of a pure green pixel
    for (k = 1; k < 4; k++) begin
      wr(`CSPP_OFS_CTRL, {26'h0, 2'(k), 4'h0});
      px(24'h00FF00, k == 1 ? 32'h55 : (k == 2 ? 32'hFF : 32'h7F));
      drain;
    end
    // stalled sink: path fills and refuses, then a slow drain keeps order
    // eight credits, plus the word parked in the output register
    wr(`CSPP_OFS_CTRL, 32'h00);
    rw <= 1'b0;
    stall <= 1'b1;
    pv <= 1'b1;
    {pr, pg, pb} <= 24'h0;
    k = 0;
    i = 0;
    while (i < 130) begin
      @(posedge mclk);
      i++;
      if (i == 30) begin
        cmp(32'(k), 32'(`CSPP_FIFO_DEPTH + 1));
        stall <= 1'b0;
        slow <= 1'b1;
      end
      if (prdy === 1'b1 && k < 12) begin
        expq.push_back(32'(k));
        k++;
        {pr, pg, pb} <= 24'(k);
      end
      if (k == 12) i = 130;
    end
    drain;
    results;
  end

  // watchdog well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    results;
  end
endmodule
